// >>> rtl/sdic_regs.vh
// Constants for the bank state and clock-enable control logic
`ifndef SDIC_REGS_VH
`define SDIC_REGS_VH

// Command codes on {row strobe, column strobe, write enable}
`define SDIC_CMD_LMR  3'h0
`define SDIC_CMD_REF  3'h1
`define SDIC_CMD_PRE  3'h2
`define SDIC_CMD_ACT  3'h3
`define SDIC_CMD_WR   3'h4
`define SDIC_CMD_RD   3'h5
`define SDIC_CMD_BST  3'h6
`define SDIC_CMD_NOP  3'h7

// Per-bank states
`define SDIC_B_IDLE   4'h0
`define SDIC_B_ACTG   4'h1
`define SDIC_B_ACT    4'h2
`define SDIC_B_RD     4'h3
`define SDIC_B_WR     4'h4
`define SDIC_B_RDA    4'h5
`define SDIC_B_WRA    4'h6
`define SDIC_B_PRE    4'h7
`define SDIC_B_WREC   4'h8

// Power modes
`define SDIC_P_NORM   3'h0
`define SDIC_P_PDN    3'h1
`define SDIC_P_SREF   3'h2
`define SDIC_P_SRX    3'h3
`define SDIC_P_SUSP   3'h4

// Field positions in the address bus
`define SDIC_AP_BIT   10
`define SDIC_CL_HI    5
`define SDIC_CL_LO    4
`define SDIC_BL_HI    2
`define SDIC_BL_LO    0

// Mode reset values
`define SDIC_CL_RST   2'h2
`define SDIC_BL_RST   3'h3

// Timing in ns and clock period in ns
`define SDIC_CLK_NS   50
`define SDIC_T_RCD_NS 20
`define SDIC_T_RP_NS  20
`define SDIC_T_WR_NS  15
`define SDIC_T_RFC_NS 66
`define SDIC_T_MRD_NS 100
`define SDIC_T_XSR_NS 67
`define SDIC_CYC(t) (((t) + `SDIC_CLK_NS - 1) / `SDIC_CLK_NS)

`endif

// >>> rtl/sdic_ctrl.v
// Bank state, burst interruption and clock-enable control logic
`include "sdic_regs.vh"

module sdic_ctrl (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Command pins
    input  wire        cke,
    input  wire        cs_n,
    input  wire        ras_n,
    input  wire        cas_n,
    input  wire        we_n,
    input  wire [1:0]  ba,
    input  wire [10:0] addr,
    // Write data
    input  wire        dqm,
    input  wire [15:0] wr_data,
    // Read data stream
    output wire [15:0] rd_data,
    output wire        rd_valid,
    input  wire        rd_ready,
    // Status
    output wire [15:0] bank_state,
    output wire        all_idle,
    output wire        cmd_ready,
    output reg  [2:0]  pwr_mode,
    output reg         cmd_err
);

    localparam integer N_RCD = `SDIC_CYC(`SDIC_T_RCD_NS);
    localparam integer N_RP  = `SDIC_CYC(`SDIC_T_RP_NS);
    localparam integer N_WR  = `SDIC_CYC(`SDIC_T_WR_NS);
    localparam integer N_RFC = `SDIC_CYC(`SDIC_T_RFC_NS);
    localparam integer N_MRD = `SDIC_CYC(`SDIC_T_MRD_NS);
    localparam integer N_XSR = `SDIC_CYC(`SDIC_T_XSR_NS);
    localparam [3:0]   C_RCD = N_RCD[3:0];
    localparam [3:0]   C_RP  = N_RP[3:0];
    localparam [3:0]   C_WR  = N_WR[3:0];
    localparam [3:0]   C_RFC = N_RFC[3:0];
    localparam [3:0]   C_MRD = N_MRD[3:0];
    localparam [3:0]   C_XSR = N_XSR[3:0];

    // Words remaining after the first one, per burst length code
    function [2:0] bl_rest;
        input [2:0] code;
        begin
            case (code)
                3'h0:    bl_rest = 3'h0;
                3'h1:    bl_rest = 3'h1;
                3'h2:    bl_rest = 3'h3;
                default: bl_rest = 3'h7;
            endcase
        end
    endfunction

    // Next column, wrapping inside the burst block
    function [2:0] next_col;
        input [2:0] col;
        input [2:0] code;
        begin
            case (code)
                3'h0:    next_col = col;
                3'h1:    next_col = {col[2:1], ~col[0]};
                3'h2:    next_col = {col[2], col[1:0] + 2'h1};
                default: next_col = col + 3'h1;
            endcase
        end
    endfunction

    // Bank may be precharged from this state
    function pre_ok;
        input [3:0] st;
        begin
            pre_ok = (st == `SDIC_B_IDLE) || (st == `SDIC_B_ACT) ||
                     (st == `SDIC_B_RD) || (st == `SDIC_B_WR) ||
                     (st == `SDIC_B_PRE);
        end
    endfunction

    reg  [3:0]  bst [0:3];
    reg  [3:0]  bcnt [0:3];
    reg  [15:0] mem [0:31];
    reg  [3:0]  gcnt;
    reg  [1:0]  cl;
    reg  [2:0]  blc;
    reg         bactive;
    reg         brd;
    reg  [1:0]  bbank;
    reg  [2:0]  bcol;
    reg  [2:0]  bleft;
    reg  [3:1]  st_v;
    reg  [4:0]  st_a [1:3];
    reg  [15:0] bufd [0:1];
    reg  [1:0]  bufn;
    reg         buf_wp;
    reg         buf_rp;
    integer     i;

    wire [2:0] cmd     = {ras_n, cas_n, we_n};
    wire       gbusy   = (gcnt != 4'h0);
    wire       is_nop  = cs_n || (cmd == `SDIC_CMD_NOP);
    wire       run     = (pwr_mode == `SDIC_P_NORM) && cke;
    wire       cmd_v   = run && !is_nop;
    wire       cmd_g   = cmd_v && !gbusy;
    wire [3:0] st_ba   = bst[ba];
    wire       ap      = addr[`SDIC_AP_BIT];
    wire       rw_ok   = (st_ba == `SDIC_B_ACT) || (st_ba == `SDIC_B_RD) ||
                         (st_ba == `SDIC_B_WR);
    wire       all_pre = pre_ok(bst[0]) && pre_ok(bst[1]) &&
                         pre_ok(bst[2]) && pre_ok(bst[3]);
    wire       idle4   = (bst[0] == `SDIC_B_IDLE) && (bst[1] == `SDIC_B_IDLE) &&
                         (bst[2] == `SDIC_B_IDLE) && (bst[3] == `SDIC_B_IDLE);
    wire       is_act  = cmd_g && (cmd == `SDIC_CMD_ACT) &&
                         (st_ba == `SDIC_B_IDLE);
    wire       is_rd   = cmd_g && (cmd == `SDIC_CMD_RD) && rw_ok;
    wire       is_wr   = cmd_g && (cmd == `SDIC_CMD_WR) && rw_ok;
    wire       is_pre  = cmd_g && (cmd == `SDIC_CMD_PRE) &&
                         (ap ? all_pre : pre_ok(st_ba));
    wire       is_ref  = cmd_g && (cmd == `SDIC_CMD_REF) && idle4;
    wire       is_lmr  = cmd_g && (cmd == `SDIC_CMD_LMR) && idle4;
    wire       is_bst  = cmd_g && (cmd == `SDIC_CMD_BST) && bactive;
    wire       new_b   = is_rd || is_wr;
    wire       buf_in_rdy = (bufn != 2'h2);
    wire       adv     = run && buf_in_rdy;
    wire       kill_b  = is_bst || (is_pre && bactive &&
                         (ap || (ba == bbank)));
    wire       done_b  = bactive && (new_b || kill_b ||
                         (adv && (bleft == 3'h0)));
    wire       wgo     = new_b || (bactive && adv && !kill_b &&
                         (bleft != 3'h0));
    wire [1:0] wbank   = new_b ? ba : bbank;
    wire [2:0] wcol    = new_b ? addr[2:0] : bcol;
    wire       wrd     = new_b ? is_rd : brd;
    wire       tap_v   = (cl == 2'h1) ? st_v[1] :
                         (cl == 2'h2) ? st_v[2] : st_v[3];
    wire [4:0] tap_a   = (cl == 2'h1) ? st_a[1] :
                         (cl == 2'h2) ? st_a[2] : st_a[3];
    wire       push    = adv && tap_v;

    assign bank_state = {bst[3], bst[2], bst[1], bst[0]};
    assign all_idle   = idle4 && !gbusy;
    assign cmd_ready  = run && !gbusy;
    assign rd_valid   = (bufn != 2'h0);
    assign rd_data    = bufd[buf_rp];

    // Power mode and clock-enable transitions
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_mode <= `SDIC_P_NORM;
        end else begin
            case (pwr_mode)
                `SDIC_P_NORM: begin
                    if (!cke) begin
                        if (is_nop && idle4 && !gbusy) begin
                            pwr_mode <= `SDIC_P_PDN;
                        end else if (!cs_n && (cmd == `SDIC_CMD_REF) &&
                                     idle4 && !gbusy) begin
                            pwr_mode <= `SDIC_P_SREF;
                        end else if (bactive) begin
                            pwr_mode <= `SDIC_P_SUSP;
                        end
                    end
                end
                `SDIC_P_PDN: begin
                    if (cke && is_nop) begin
                        pwr_mode <= `SDIC_P_NORM;
                    end
                end
                `SDIC_P_SREF: begin
                    if (cke && is_nop) begin
                        pwr_mode <= `SDIC_P_SRX;
                    end
                end
                `SDIC_P_SRX: begin
                    if (gcnt <= 4'h1) begin
                        pwr_mode <= `SDIC_P_NORM;
                    end
                end
                `SDIC_P_SUSP: begin
                    if (cke) begin
                        pwr_mode <= `SDIC_P_NORM;
                    end
                end
                default: pwr_mode <= `SDIC_P_NORM;
            endcase
        end
    end

    // Refresh, mode load and self refresh exit busy timer
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gcnt <= 4'h0;
        end else if (is_ref) begin
            gcnt <= C_RFC;
        end else if (is_lmr) begin
            gcnt <= C_MRD;
        end else if ((pwr_mode == `SDIC_P_SREF) && cke && is_nop) begin
            gcnt <= C_XSR;
        end else if (gbusy) begin
            gcnt <= gcnt - 4'h1;
        end
    end

    // Mode register and refused-command flag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cl      <= `SDIC_CL_RST;
            blc     <= `SDIC_BL_RST;
            cmd_err <= 1'b0;
        end else begin
            if (is_lmr) begin
                cl  <= addr[`SDIC_CL_HI:`SDIC_CL_LO];
                blc <= addr[`SDIC_BL_HI:`SDIC_BL_LO];
            end
            cmd_err <= (cmd_v && !(is_act || new_b || is_pre ||
                        is_ref || is_lmr || is_bst)) ||
                       ((pwr_mode == `SDIC_P_SRX) && !is_nop);
        end
    end

    // Burst generator; a new burst takes over at once
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bactive <= 1'b0;
            brd     <= 1'b0;
            bbank   <= 2'h0;
            bcol    <= 3'h0;
            bleft   <= 3'h0;
        end else if (new_b) begin
            bactive <= 1'b1;
            brd     <= is_rd;
            bbank   <= ba;
            bcol    <= next_col(addr[2:0], blc);
            bleft   <= bl_rest(blc);
        end else if (kill_b) begin
            bactive <= 1'b0;
        end else if (bactive && adv) begin
            if (bleft == 3'h0) begin
                bactive <= 1'b0;
            end else begin
                bcol  <= next_col(bcol, blc);
                bleft <= bleft - 3'h1;
            end
        end
    end

    // Write data capture; mask blocks the word
    always @(posedge clk) begin
        if (wgo && !wrd && !dqm) begin
            mem[{wbank, wcol}] <= wr_data;
        end
    end

    // Read latency pipeline, emptied by an accepted write command, held while suspended, and while stalled until a read command is accepted
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_v    <= 3'h0;
            st_a[1] <= 5'h00;
            st_a[2] <= 5'h00;
            st_a[3] <= 5'h00;
        end else if (is_wr) begin
            st_v <= 3'h0;
        end else if (adv || new_b) begin
            st_v    <= {st_v[2:1], wgo && wrd};
            st_a[1] <= {wbank, wcol};
            st_a[2] <= st_a[1];
            st_a[3] <= st_a[2];
        end
    end

    // Two-entry read data buffer
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bufn    <= 2'h0;
            buf_wp  <= 1'b0;
            buf_rp  <= 1'b0;
            bufd[0] <= 16'h0000;
            bufd[1] <= 16'h0000;
        end else begin
            if (push) begin
                bufd[buf_wp] <= mem[tap_a];
                buf_wp       <= ~buf_wp;
            end
            if (rd_valid && rd_ready) begin
                buf_rp <= ~buf_rp;
            end
            bufn <= bufn + {1'b0, push} -
                    {1'b0, rd_valid && rd_ready};
        end
    end

    // Per-bank state machines
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                bst[i]  <= `SDIC_B_IDLE;
                bcnt[i] <= 4'h0;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (is_act && (ba == i[1:0])) begin
                    bst[i]  <= `SDIC_B_ACTG;
                    bcnt[i] <= C_RCD;
                end else if (new_b && (ba == i[1:0])) begin
                    bst[i] <= is_rd ?
                              (ap ? `SDIC_B_RDA : `SDIC_B_RD) :
                              (ap ? `SDIC_B_WRA : `SDIC_B_WR);
                end else if (is_pre && (ap || (ba == i[1:0])) &&
                             (bst[i] != `SDIC_B_IDLE) &&
                             (bst[i] != `SDIC_B_PRE)) begin
                    bst[i]  <= `SDIC_B_PRE;
                    bcnt[i] <= C_RP;
                end else if (done_b && (bbank == i[1:0])) begin
                    case (bst[i])
                        `SDIC_B_RDA: begin
                            bst[i]  <= `SDIC_B_PRE;
                            bcnt[i] <= C_RP;
                        end
                        `SDIC_B_WRA: begin
                            bst[i]  <= `SDIC_B_WREC;
                            bcnt[i] <= C_WR;
                        end
                        default: bst[i] <= `SDIC_B_ACT;
                    endcase
                end else if (bcnt[i] > 4'h1) begin
                    bcnt[i] <= bcnt[i] - 4'h1;
                end else begin
                    bcnt[i] <= 4'h0;
                    case (bst[i])
                        `SDIC_B_ACTG: bst[i] <= `SDIC_B_ACT;
                        `SDIC_B_PRE:  bst[i] <= `SDIC_B_IDLE;
                        `SDIC_B_WREC: begin
                            bst[i]  <= `SDIC_B_PRE;
                            bcnt[i] <= C_RP;
                        end
                        default: bst[i] <= bst[i];
                    endcase
                end
            end
        end
    end

endmodule // sdic_ctrl

// >>> bench/sdic_checker.sv
// Port checker for bank state, interruption and clock-enable behaviour
`include "sdic_regs.vh"
module sdic_checker (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Command pins
    input wire        cke,
    input wire        cs_n,
    input wire        ras_n,
    input wire        cas_n,
    input wire        we_n,
    input wire [1:0]  ba,
    // Read stream and status
    input wire [15:0] rd_data,
    input wire        rd_valid,
    input wire        rd_ready,
    input wire [15:0] bank_state,
    input wire        all_idle,
    input wire        cmd_ready,
    input wire [2:0]  pwr_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire [2:0] cmd  = {ras_n, cas_n, we_n};
    wire       nop  = cs_n | (cmd == `SDIC_CMD_NOP);
    wire       norm = (pwr_mode == `SDIC_P_NORM);
    wire [3:0] b0   = bank_state[3:0];
    wire       intr = cmd_ready & !cs_n & (ba == 2'h1)
                      & (bank_state[7:4] == `SDIC_B_ACT)
                      & ((cmd == `SDIC_CMD_RD) | (cmd == `SDIC_CMD_WR));
    sequence pre_then_idle;
        (b0 == `SDIC_B_PRE) ##1 (b0 == `SDIC_B_IDLE);
    endsequence
    sequence rec_then_pre;
        (b0 == `SDIC_B_WREC) ##1 pre_then_idle;
    endsequence
    deselect_idle_a: assert property (
        cs_n & norm & cke & all_idle |=> bank_state == 16'h0000
    ) else $error("deselect changed a bank");
    nop_idle_a: assert property (
        !cs_n & nop & norm & cke & all_idle |=> all_idle
    ) else $error("no-op left idle state");
    pdn_entry_a: assert property (
        norm & !cke & all_idle & nop |=> pwr_mode == `SDIC_P_PDN
    ) else $error("power-down not entered");
    sref_entry_a: assert property (
        norm & !cke & all_idle & !cs_n & (cmd == `SDIC_CMD_REF)
        |=> pwr_mode == `SDIC_P_SREF
    ) else $error("self refresh not entered");
    pdn_exit_a: assert property (
        (pwr_mode == `SDIC_P_PDN) & cke & nop |=> norm & (cmd_ready | !cke)
    ) else $error("power-down exit not ready");
    srx_busy_a: assert property (
        pwr_mode == `SDIC_P_SRX |-> !all_idle & !cmd_ready
    ) else $error("idle during self refresh exit");
    srx_end_a: assert property (
        $rose(pwr_mode == `SDIC_P_SRX) |-> ##[1:3] norm & all_idle
    ) else $error("self refresh exit too long");
    susp_hold_a: assert property (
        (pwr_mode == `SDIC_P_SUSP) & !cke
        |=> (pwr_mode == `SDIC_P_SUSP) & $stable(bank_state)
    ) else $error("suspend not held");
    susp_exit_a: assert property (
        (pwr_mode == `SDIC_P_SUSP) & cke |=> norm
    ) else $error("suspend exit late");
    rdap_intr_a: assert property (
        intr & (b0 == `SDIC_B_RDA) |=> pre_then_idle
    ) else $error("read auto precharge not started");
    wrap_intr_a: assert property (
        intr & (b0 == `SDIC_B_WRA) |=> rec_then_pre
    ) else $error("write recovery not followed");
    buf_hold_a: assert property (
        rd_valid & !rd_ready |=> rd_valid & $stable(rd_data)
    ) else $error("stalled read word lost");
endmodule // sdic_checker

bind sdic_ctrl sdic_checker chk_u (
    .clk, .arst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .rd_data,
    .rd_valid, .rd_ready, .bank_state, .all_idle, .cmd_ready, .pwr_mode
);

// >>> bench/sdic_sink.sv
// Read stream sink that can stall and records the last word it takes and a count of words
module sdic_sink (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Read stream
    input  wire [15:0] rd_data,
    input  wire        rd_valid,
    output wire        rd_ready,
    // Control and record
    input  wire        stall,
    output reg  [15:0] last,
    output reg  [7:0]  count
);
    timeunit 1ns;
    timeprecision 1ns;
    assign rd_ready = !stall;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last  <= 16'h0000;
            count <= 8'h00;
        end else if (rd_valid && rd_ready) begin
            last  <= rd_data;
            count <= count + 8'h01;
        end
    end
endmodule // sdic_sink

// >>> bench/tb_sdram_interbank_cke_control.sv
// Self-checking bench for the bank state and clock-enable logic
`include "sdic_regs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected at %0t got %h expected %h", $time, a, e); end end
module tb_sdram_interbank_cke_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] C_LMR = `SDIC_CMD_LMR, C_REF = `SDIC_CMD_REF,
        C_PRE = `SDIC_CMD_PRE, C_ACT = `SDIC_CMD_ACT, C_WR = `SDIC_CMD_WR,
        C_RD = `SDIC_CMD_RD, C_BST = `SDIC_CMD_BST, C_NOP = `SDIC_CMD_NOP;
    // Stimulus, design outputs and sink record
    logic        clk, arst_n, cke, cs_n, ras_n, cas_n, we_n, stall, dqm;
    logic [1:0]  ba;
    logic [10:0] addr;
    logic [15:0] wr_data;
    wire  [15:0] rd_data, bank_state, last;
    wire         rd_valid, rd_ready, all_idle, cmd_ready, cmd_err;
    wire  [2:0]  pwr_mode;
    wire  [7:0]  count;
    logic [7:0]  nrx;
    int          err_total, n_tests;
    sdic_ctrl dut_u (
        .clk, .arst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
        .dqm, .wr_data, .rd_data, .rd_valid, .rd_ready, .bank_state,
        .all_idle, .cmd_ready, .pwr_mode, .cmd_err
    );
    sdic_sink sink_u (
        .clk, .arst_n, .rd_data, .rd_valid, .rd_ready, .stall, .last, .count
    );
    task automatic cmd(input logic [2:0] c, input logic [1:0] b,
        input logic [10:0] a = 11'h000, input logic [15:0] d = 16'h0000);
        {ras_n, cas_n, we_n, ba, addr, wr_data} = {c, b, a, d};
        @(negedge clk);
    endtask
    task automatic nops(input int n);
        repeat (n) cmd(C_NOP, 2'h0);
    endtask
    task automatic expect_word(input logic [15:0] e);
        int k;
        for (k = 0; k < 40 && count == nrx; k++) @(negedge clk);
        `CHK({count - nrx, last}, {8'h01, e})
        nrx = nrx + 8'h01;
    endtask
    task automatic refused(input logic [2:0] c);
        logic e;
        cmd(c, 2'h2, 11'h021);
        e = cmd_err;
        nops(1);
        `CHK(e | cmd_err, 1'b1)
    endtask
    task automatic t_setup;
        logic e;
        `CHK({bank_state, pwr_mode, rd_valid}, 20'h00000)
        cmd(C_LMR, 2'h0, 11'h021);
        nops(3);
        cmd(C_ACT, 2'h0);
        cmd(C_ACT, 2'h1);
        nops(1);
        `CHK(bank_state, 16'h0022)
        refused(C_LMR);
        refused(C_REF);
        refused(C_BST);
        cs_n = 1'b1;
        cmd(C_ACT, 2'h2);
        cs_n = 1'b0;
        e = cmd_err;
        nops(1);
        `CHK({e | cmd_err, bank_state}, 17'h00022)
        $display("setup done");
    endtask
    task automatic t_data;
        nrx = count;
        cmd(C_WR, 2'h0, 11'h000, 16'hA0A0);
        cmd(C_NOP, 2'h0, 11'h000, 16'hA1A1);
        cmd(C_WR, 2'h0, 11'h000, 16'h1111);
        cmd(C_WR, 2'h1, 11'h000, 16'h2222);
        cmd(C_NOP, 2'h0, 11'h000, 16'h3333);
        dqm = 1'b1;
        cmd(C_WR, 2'h0, 11'h000, 16'h5555);
        dqm = 1'b0;
        cmd(C_RD, 2'h1);
        cmd(C_RD, 2'h0);
        cmd(C_RD, 2'h1);
        nops(1);
        expect_word(16'h2222);
        expect_word(16'h1111);
        expect_word(16'h2222);
        expect_word(16'h3333);
        stall = 1'b1;
        cmd(C_RD, 2'h0);
        cmd(C_PRE, 2'h2);
        nops(6);
        `CHK({rd_valid, count}, {1'b1, nrx})
        stall = 1'b0;
        expect_word(16'h1111);
        expect_word(16'hA1A1);
        cmd(C_RD, 2'h1);
        cke = 1'b0;
        nops(2);
        `CHK({pwr_mode, bank_state[7:4]}, {`SDIC_P_SUSP, `SDIC_B_RD})
        cke = 1'b1;
        nops(1);
        `CHK(pwr_mode, `SDIC_P_NORM)
        expect_word(16'h2222);
        expect_word(16'h3333);
        cmd(C_RD, 2'h0);
        cmd(C_BST, 2'h2);
        nops(1);
        `CHK(bank_state, 16'h0022)
        $display("data done");
    endtask
    task automatic t_ap;
        int i;
        logic [7:0] base, nw, x;
        for (i = 0; i < 4; i++) begin
            cmd(i[1] ? C_WR : C_RD, 2'h0, 11'h400, 16'h6666);
            base = count;
            nw = (i == 0) ? 8'h03 : (i == 2) ? 8'h02 : 8'h00;
            x[7:4] = i[0] ? `SDIC_B_WR : `SDIC_B_RD;
            x[3:0] = i[1] ? `SDIC_B_WREC : `SDIC_B_PRE;
            cmd(i[0] ? C_WR : C_RD, 2'h1, 11'h000, 16'h7777);
            `CHK(bank_state[7:0], x)
            nops(4);
            `CHK(count - base, nw)
            `CHK(bank_state, 16'h0020)
            cmd(C_ACT, 2'h0);
            nops(1);
        end
        $display("auto precharge done");
    endtask
    task automatic t_power;
        int k;
        cmd(C_PRE, 2'h0, 11'h400);
        nops(3);
        `CHK(all_idle, 1'b1)
        cs_n = 1'b1;
        cmd(C_ACT, 2'h3);
        cs_n = 1'b0;
        `CHK(bank_state, 16'h0000)
        cke = 1'b0;
        nops(2);
        `CHK(pwr_mode, `SDIC_P_PDN)
        cke = 1'b1;
        nops(1);
        `CHK({pwr_mode, cmd_ready}, {`SDIC_P_NORM, 1'b1})
        cmd(C_ACT, 2'h2);
        nops(1);
        `CHK(bank_state[11:8], `SDIC_B_ACT)
        cmd(C_PRE, 2'h2);
        nops(2);
        cke = 1'b0;
        cmd(C_REF, 2'h0);
        nops(1);
        `CHK(pwr_mode, `SDIC_P_SREF)
        cke = 1'b1;
        nops(1);
        `CHK({pwr_mode, all_idle}, {`SDIC_P_SRX, 1'b0})
        nops(2);
        for (k = 0; k < 4 && all_idle !== 1'b1; k++) nops(1);
        `CHK({pwr_mode, all_idle}, {`SDIC_P_NORM, 1'b1})
        $display("power done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end
    initial begin
        {arst_n, cke, cs_n, stall, dqm} = 5'h08;
        {ras_n, cas_n, we_n, ba, addr, wr_data} = {C_NOP, 29'h0};
        nrx = 8'h00;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        t_setup();
        t_data();
        t_ap();
        t_power();
        tally_and_finish();
    end
endmodule // tb_sdram_interbank_cke_control
